// [core/iwr_top.sv]
`timescale 1ns/1ps
// Behaviour
// - chroma averaging bit set averages two neighbouring chroma bytes before output.
// - byte swap exchanges Y and C bytes in YCbCr, odd and even bytes in RGB.
// - channel swap exchanges Cb and Cr in YCbCr, red and blue in RGB.
// - RGB enable clear selects YCbCr, set selects RGB; it steers the swaps.
// - horizontal origin is column zero when select clear, column 640 when set.
// - horizontal pan is unsigned from zero, two's complement from centre.
// - vertical origin is row zero when select clear, row 512 when set.
// - vertical pan is unsigned from row zero, two's complement from row 512.
// - context B registers its whole set, context A only the horizontal part (vertical from input ports); active context's set is used.
// - zoom window width comes from each context's 11-bit horizontal zoom.
// - zoom window height comes from each context's 11-bit vertical zoom.
// - context B resets to zero pans, 0x0500 widths and 0x0400 heights.
// - context A resets to zero pan, 0x0500 zoom width, 0x0280 output width.
module iwr_top
  import iwr_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [REG_DW-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  output logic [REG_DW-1:0]      reg_rdata_o,
  // Loose configuration
  input  wire logic              ctx_b_sel_i,
  input  wire iwr_pan_t          ctx_a_vertical_pan_i,
  input  wire logic [10:0]       ctx_a_vertical_zoom_i,
  input  wire logic [10:0]       ctx_a_vertical_out_size_i,
  input  wire iwr_fmt_t          fmt_i,
  // Pixel stream from the colour pipeline
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  input  wire iwr_pixel_t        in_pixel_i,
  // Formatted stream to the output interface
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [OUT_W-1:0]       out_data_o
);

  // ============================================================
  // Register file
  iwr_pan_t    b_hpan;
  logic [10:0] b_hzoom;
  logic [10:0] b_hsize;
  iwr_pan_t    b_vpan;
  logic [10:0] b_vzoom;
  logic [10:0] b_vsize;
  iwr_pan_t    a_hpan;
  logic [10:0] a_hzoom;
  logic [10:0] a_hsize;

  // Write strobes per register
  wire wr_b_hpan  = reg_wr_i && (reg_addr_i == ADDR_CTX_B_HPAN);
  wire wr_b_hzoom = reg_wr_i && (reg_addr_i == ADDR_CTX_B_HZOOM);
  wire wr_b_hsize = reg_wr_i && (reg_addr_i == ADDR_CTX_B_HSIZE);
  wire wr_b_vpan  = reg_wr_i && (reg_addr_i == ADDR_CTX_B_VPAN);
  wire wr_b_vzoom = reg_wr_i && (reg_addr_i == ADDR_CTX_B_VZOOM);
  wire wr_b_vsize = reg_wr_i && (reg_addr_i == ADDR_CTX_B_VSIZE);
  wire wr_a_hpan  = reg_wr_i && (reg_addr_i == ADDR_CTX_A_HPAN);
  wire wr_a_hzoom = reg_wr_i && (reg_addr_i == ADDR_CTX_A_HZOOM);
  wire wr_a_hsize = reg_wr_i && (reg_addr_i == ADDR_CTX_A_HSIZE);

  // Pan fields keep only the origin select and the offset
  iwr_pan_t wr_pan;
  assign wr_pan = '{centre: reg_wdata_i[PAN_CENTRE_BIT], offset: reg_wdata_i[FIELD_W-1:0]};

  // Defaults of both contexts
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      b_hpan  <= '{centre: 1'b0, offset: RST_PAN};
      b_hzoom <= RST_B_HZOOM;
      b_hsize <= RST_B_HSIZE;
      b_vpan  <= '{centre: 1'b0, offset: RST_PAN};
      b_vzoom <= RST_B_VZOOM;
      b_vsize <= RST_B_VSIZE;
      a_hpan  <= '{centre: 1'b0, offset: RST_PAN};
      a_hzoom <= RST_A_HZOOM;
      a_hsize <= RST_A_HSIZE;
    end else begin
      if (wr_b_hpan)  b_hpan  <= wr_pan;
      if (wr_b_hzoom) b_hzoom <= reg_wdata_i[FIELD_W-1:0];
      if (wr_b_hsize) b_hsize <= reg_wdata_i[FIELD_W-1:0];
      if (wr_b_vpan)  b_vpan  <= wr_pan;
      if (wr_b_vzoom) b_vzoom <= reg_wdata_i[FIELD_W-1:0];
      if (wr_b_vsize) b_vsize <= reg_wdata_i[FIELD_W-1:0];
      if (wr_a_hpan)  a_hpan  <= wr_pan;
      if (wr_a_hzoom) a_hzoom <= reg_wdata_i[FIELD_W-1:0];
      if (wr_a_hsize) a_hsize <= reg_wdata_i[FIELD_W-1:0];
    end
  end

  // ============================================================
  // Read-back; reserved bits and unmapped indices read zero
  function automatic logic [REG_DW-1:0] pan_word(iwr_pan_t p);
    pan_word = {1'b0, p.centre, 3'h0, p.offset};
  endfunction : pan_word

  logic [REG_DW-1:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      ADDR_CTX_B_HPAN:  rd_mux = pan_word(b_hpan);
      ADDR_CTX_B_HZOOM: rd_mux = {5'h00, b_hzoom};
      ADDR_CTX_B_HSIZE: rd_mux = {5'h00, b_hsize};
      ADDR_CTX_B_VPAN:  rd_mux = pan_word(b_vpan);
      ADDR_CTX_B_VZOOM: rd_mux = {5'h00, b_vzoom};
      ADDR_CTX_B_VSIZE: rd_mux = {5'h00, b_vsize};
      ADDR_CTX_A_HPAN:  rd_mux = pan_word(a_hpan);
      ADDR_CTX_A_HZOOM: rd_mux = {5'h00, a_hzoom};
      ADDR_CTX_A_HSIZE: rd_mux = {5'h00, a_hsize};
      default:          rd_mux = 16'h0000;
    endcase
  end

  // Read data is registered, one cycle after the index
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) reg_rdata_o <= 16'h0000;
    else          reg_rdata_o <= rd_mux;
  end

  // ============================================================
  // Context selection; a switch takes effect only at a frame start
  iwr_ctx_t ctx_a;
  iwr_ctx_t ctx_b;
  iwr_ctx_t ctx;
  logic     sel_b;
  logic     cur_sel_b;
  wire      take = in_valid_i && in_ready_o;

  assign ctx_a = '{h_pan: a_hpan, h_zoom: a_hzoom, h_size: a_hsize,
                   v_pan: ctx_a_vertical_pan_i, v_zoom: ctx_a_vertical_zoom_i,
                   v_size: ctx_a_vertical_out_size_i};
  assign ctx_b = '{h_pan: b_hpan, h_zoom: b_hzoom, h_size: b_hsize,
                   v_pan: b_vpan, v_zoom: b_vzoom, v_size: b_vsize};
  // Switching mid-frame would tear the image, so hold the choice until sof
  assign cur_sel_b = in_pixel_i.sof ? ctx_b_sel_i : sel_b;
  assign ctx       = cur_sel_b ? ctx_b : ctx_a;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i)                   sel_b <= 1'b0;
    else if (take && in_pixel_i.sof) sel_b <= ctx_b_sel_i;
  end

  // ============================================================
  // Sensor coordinates of the pixel at the input
  logic [COORD_W-1:0] col;
  logic [COORD_W-1:0] row;
  logic [COORD_W-1:0] cur_col;
  logic [COORD_W-1:0] cur_row;

  assign cur_col = in_pixel_i.sol ? '0 : col + 1'b1;
  assign cur_row = in_pixel_i.sof ? '0 : (in_pixel_i.sol ? row + 1'b1 : row);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col <= '0;
      row <= '0;
    end else if (take) begin
      col <= cur_col;
      row <= cur_row;
    end
  end

  // ============================================================
  // Window placement from origin, pan and zoom
  // Centred windows sit with their middle on the origin plus pan
  function automatic logic signed [COORD_W-1:0] win_start(iwr_pan_t p, logic [10:0] zoom,
                                                          logic [COORD_W-1:0] origin);
    logic signed [COORD_W-1:0] off_s;
    logic signed [COORD_W-1:0] half;
    off_s = COORD_W'(signed'(p.offset));
    half  = signed'({4'h0, zoom[10:1]});
    if (p.centre) win_start = signed'(origin) + off_s - half;
    else          win_start = signed'({3'h0, p.offset});
  endfunction : win_start

  logic signed [COORD_W-1:0] h_start;
  logic signed [COORD_W-1:0] h_end;
  logic signed [COORD_W-1:0] v_start;
  logic signed [COORD_W-1:0] v_end;
  logic                      h_in;
  logic                      v_in;

  assign h_start = win_start(ctx.h_pan, ctx.h_zoom, H_ORIGIN);
  assign h_end   = h_start + signed'({3'h0, ctx.h_zoom});
  assign v_start = win_start(ctx.v_pan, ctx.v_zoom, V_ORIGIN);
  assign v_end   = v_start + signed'({3'h0, ctx.v_zoom});
  assign h_in    = (signed'(cur_col) >= h_start) && (signed'(cur_col) < h_end);
  assign v_in    = (signed'(cur_row) >= v_start) && (signed'(cur_row) < v_end);

  // ============================================================
  // Scaling: horizontal and vertical decimation accumulators
  // Relies on size never exceeding zoom, otherwise every sample is kept
  logic h_keep;
  logic v_keep;
  logic line_keep;
  logic cur_line_keep;
  logic pix_keep;

  iwr_dda u_h_dda (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .restart_i (take && in_pixel_i.sol),
    .advance_i (take && h_in),
    .step_i    (ctx.h_size),
    .modulus_i (ctx.h_zoom),
    .keep_o    (h_keep)
  );

  iwr_dda u_v_dda (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .restart_i (take && in_pixel_i.sof),
    .advance_i (take && in_pixel_i.sol && v_in),
    .step_i    (ctx.v_size),
    .modulus_i (ctx.v_zoom),
    .keep_o    (v_keep)
  );

  // Row decision is made once, on the first pixel of the line
  assign cur_line_keep = in_pixel_i.sol ? (v_in && v_keep) : line_keep;
  assign pix_keep      = cur_line_keep && h_in && h_keep;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i)  line_keep <= 1'b0;
    else if (take) line_keep <= cur_line_keep;
  end

  // ============================================================
  // Output formatting
  logic [7:0]  prev_cb;
  logic [7:0]  prev_cr;
  logic        phase;
  logic        cur_phase;
  logic        first;
  logic [7:0]  cb_now;
  logic [7:0]  cr_now;
  logic [8:0]  cb_sum;
  logic [8:0]  cr_sum;
  logic [7:0]  cb_out;
  logic [7:0]  cr_out;
  logic [7:0]  chroma;
  logic [7:0]  red;
  logic [7:0]  blue;
  logic [15:0] rgb_word;
  logic [15:0] ycc_word;
  logic [15:0] fmt_word;

  // Chroma phase restarts on every line so lines start on the same channel
  assign first     = in_pixel_i.sol;
  assign cur_phase = first ? 1'b0 : phase;

  // Average with the previous kept pixel; the first of a line pairs with itself
  assign cb_now = in_pixel_i.c1;
  assign cr_now = in_pixel_i.c2;
  assign cb_sum = {1'b0, cb_now} + {1'b0, (first ? cb_now : prev_cb)};
  assign cr_sum = {1'b0, cr_now} + {1'b0, (first ? cr_now : prev_cr)};
  assign cb_out = fmt_i.chroma_avg ? cb_sum[8:1] : cb_now;
  assign cr_out = fmt_i.chroma_avg ? cr_sum[8:1] : cr_now;

  // Channel swap inverts which chroma a phase carries
  assign chroma   = (cur_phase ^ fmt_i.chan_swap) ? cr_out : cb_out;
  assign ycc_word = fmt_i.byte_swap ? {chroma, in_pixel_i.c0}
                                    : {in_pixel_i.c0, chroma};

  // RGB packs as 565; swaps act on channels and bytes
  assign red      = fmt_i.chan_swap ? in_pixel_i.c2 : in_pixel_i.c0;
  assign blue     = fmt_i.chan_swap ? in_pixel_i.c0 : in_pixel_i.c2;
  assign rgb_word = fmt_i.byte_swap ? {in_pixel_i.c1[4:2], blue[7:3], red[7:3], in_pixel_i.c1[7:5]}
                                    : {red[7:3], in_pixel_i.c1[7:2], blue[7:3]};
  assign fmt_word = fmt_i.rgb_en ? rgb_word : ycc_word;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase   <= 1'b0;
      prev_cb <= 8'h00;
      prev_cr <= 8'h00;
    end else if (take && pix_keep) begin
      phase   <= ~cur_phase;
      prev_cb <= cb_now;
      prev_cr <= cr_now;
    end else if (take && first) begin
      phase   <= 1'b0;
    end
  end

  // ============================================================
  // Output buffering and the registered output stage
  logic             fifo_valid;
  logic [OUT_W-1:0] fifo_data;
  wire              stage_load = !out_valid_o || out_ready_i;

  // Input ready follows buffer space, so back-pressure reaches the pipeline
  iwr_fifo #(
    .W     (OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .wr_valid_i (in_valid_i && pix_keep),
    .wr_ready_o (in_ready_o),
    .wr_data_i  (fmt_word),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (stage_load),
    .rd_data_o  (fifo_data)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= 16'h0000;
    end else if (stage_load) begin
      out_valid_o <= fifo_valid;
      if (fifo_valid) out_data_o <= fifo_data;
    end
  end

endmodule : iwr_top

// [pkg/iwr_pkg.sv]
// ============================================================
// Shared constants and carriers of the image window reducer
package iwr_pkg;

  // ============================================================
  // Widths
  localparam int unsigned FIELD_W    = 11;
  localparam int unsigned COORD_W    = 14;
  localparam int unsigned REG_AW     = 9;
  localparam int unsigned REG_DW     = 16;
  localparam int unsigned OUT_W      = 16;
  localparam int unsigned FIFO_DEPTH = 4;

  // ============================================================
  // Register offsets, printed indices
  localparam logic [8:0] ADDR_CTX_B_HPAN  = 9'h19F;
  localparam logic [8:0] ADDR_CTX_B_HZOOM = 9'h1A0;
  localparam logic [8:0] ADDR_CTX_B_HSIZE = 9'h1A1;
  localparam logic [8:0] ADDR_CTX_B_VPAN  = 9'h1A2;
  localparam logic [8:0] ADDR_CTX_B_VZOOM = 9'h1A3;
  localparam logic [8:0] ADDR_CTX_B_VSIZE = 9'h1A4;
  localparam logic [8:0] ADDR_CTX_A_HPAN  = 9'h1A5;
  localparam logic [8:0] ADDR_CTX_A_HZOOM = 9'h1A6;
  localparam logic [8:0] ADDR_CTX_A_HSIZE = 9'h1A7;

  // ============================================================
  // Field positions
  localparam int unsigned PAN_CENTRE_BIT = 14;

  // ============================================================
  // Reset values
  localparam logic [10:0] RST_PAN     = 11'h000;
  localparam logic [10:0] RST_B_HZOOM = 11'h500;
  localparam logic [10:0] RST_B_HSIZE = 11'h500;
  localparam logic [10:0] RST_B_VZOOM = 11'h400;
  localparam logic [10:0] RST_B_VSIZE = 11'h400;
  localparam logic [10:0] RST_A_HZOOM = 11'h500;
  localparam logic [10:0] RST_A_HSIZE = 11'h280;

  // ============================================================
  // Centred origins
  localparam logic [13:0] H_ORIGIN = 14'h0280;
  localparam logic [13:0] V_ORIGIN = 14'h0200;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic       sof;
    logic       sol;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } iwr_pixel_t;

  typedef struct packed {
    logic        centre;
    logic [10:0] offset;
  } iwr_pan_t;

  typedef struct packed {
    iwr_pan_t    h_pan;
    logic [10:0] h_zoom;
    logic [10:0] h_size;
    iwr_pan_t    v_pan;
    logic [10:0] v_zoom;
    logic [10:0] v_size;
  } iwr_ctx_t;

  typedef struct packed {
    logic rgb_en;
    logic chroma_avg;
    logic byte_swap;
    logic chan_swap;
  } iwr_fmt_t;

endpackage : iwr_pkg

// [core/iwr_fifo.sv]
`timescale 1ns/1ps
// ============================================================
// Small synchronous FIFO with registered write ready
module iwr_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  input  wire logic [W-1:0] wr_data_i,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [W-1:0]      rd_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic [PW:0]   next_count;
  wire           do_wr = wr_valid_i && wr_ready_o;
  wire           do_rd = rd_valid_o && rd_ready_i;

  // Occupancy after this edge
  assign next_count = count + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd};
  assign rd_valid_o = (count != '0);
  assign rd_data_o  = mem[rd_ptr];

  // Ready is registered so it can leave the block straight from a flop
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      wr_ready_o <= 1'b1;
    end else begin
      if (do_wr) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count      <= next_count;
      wr_ready_o <= (next_count < (PW + 1)'(DEPTH));
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_sys_i) begin
    if (do_wr) mem[wr_ptr] <= wr_data_i;
  end
endmodule : iwr_fifo

// [core/iwr_dda.sv]
`timescale 1ns/1ps
// ============================================================
// Decimating accumulator: keeps step of every modulus samples
module iwr_dda (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        restart_i,
  input  wire logic        advance_i,
  input  wire logic [10:0] step_i,
  input  wire logic [10:0] modulus_i,
  output logic             keep_o
);
  logic [11:0] acc;
  logic [11:0] base;
  logic [11:0] sum;

  // Restart acts on the same sample, so the first sample of a span is judged from zero
  assign base   = restart_i ? 12'h000 : acc;
  assign sum    = base + {1'b0, step_i};
  assign keep_o = (sum >= {1'b0, modulus_i});

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc <= 12'h000;
    end else if (advance_i) begin
      acc <= keep_o ? sum - {1'b0, modulus_i} : sum;
    end else if (restart_i) begin
      acc <= 12'h000;
    end
  end
endmodule : iwr_dda

// [dv/iwr_rx_model.sv]
`timescale 1ns/1ps
// ============================================================
// Receiver model: accepts words with random back-pressure
module iwr_rx_model (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic stall_i,
  output logic      out_ready_o
);
  // Ready is held low through a stall so the FIFO fills
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_ready_o <= 1'h0;
    end else begin
      out_ready_o <= !stall_i && ($urandom % 4 != 0);
    end
  end
endmodule : iwr_rx_model

// [dv/iwr_assertions.sv]
`timescale 1ns/1ps
// ============================================================
// Port checks of the window reducer
module iwr_assertions
  import iwr_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rst_b_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic [REG_DW-1:0] reg_rdata_o,
  input wire logic              out_valid_o,
  input wire logic              out_ready_i,
  input wire logic [OUT_W-1:0]  out_data_o
);
  // No write since reset: defaults must still read back
  logic clean;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clean <= 1'h1;
    end else if (reg_wr_i) begin
      clean <= 1'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ============================================================
  // Readback keeps only the documented bits
  b_hpan_a: assert property (reg_wr_i && reg_addr_i == ADDR_CTX_B_HPAN ##1 !reg_wr_i && $stable(reg_addr_i)
    ##1 $stable(reg_addr_i) |-> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h47FF)) else $error("pan readback");
  b_vpan_a: assert property (reg_wr_i && reg_addr_i == ADDR_CTX_B_VPAN ##1 !reg_wr_i && $stable(reg_addr_i)
    ##1 $stable(reg_addr_i) |-> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h47FF)) else $error("vpan readback");
  a_hzoom_a: assert property (reg_wr_i && reg_addr_i == ADDR_CTX_A_HZOOM ##1 !reg_wr_i && $stable(reg_addr_i)
    ##1 $stable(reg_addr_i) |-> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h07FF)) else $error("zoom readback");
  b_vzoom_a: assert property (reg_wr_i && reg_addr_i == ADDR_CTX_B_VZOOM ##1 !reg_wr_i && $stable(reg_addr_i)
    ##1 $stable(reg_addr_i) |-> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h07FF)) else $error("height readback");
  // Reset values, unmapped reads and output holding
  a_size_rst_a: assert property (clean && !reg_wr_i && reg_addr_i == ADDR_CTX_A_HSIZE
    |=> reg_rdata_o == 16'h0280) else $error("A size default");
  b_vzoom_rst_a: assert property (clean && !reg_wr_i && reg_addr_i == ADDR_CTX_B_VZOOM
    |=> reg_rdata_o == 16'h0400) else $error("B height default");
  unmapped_zero_a: assert property (!(reg_addr_i inside {[ADDR_CTX_B_HPAN:ADDR_CTX_A_HSIZE]})
    |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
  out_hold_a: assert property (out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(out_data_o)) else $error("word dropped");
endmodule : iwr_assertions

bind iwr_top iwr_assertions iwr_assertions_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .out_data_o(out_data_o));

// [dv/tb_top.sv]
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the window reducer
module tb_top;
  import iwr_pkg::*;
  logic [8:0]  reg_addr_i = '0;
  logic [15:0] reg_wdata_i = '0;
  logic [15:0] reg_rdata_o, out_data_o, cnt = '0;
  logic [15:0] expq[$];
  logic [15:0] rv[10] = '{16'h0000, 16'h0500, 16'h0500, 16'h0000, 16'h0400, 16'h0400, 16'h0000, 16'h0500,
                          16'h0280, 16'h0000};
  logic        clk_sys_i = 0, rst_b_i = 0, reg_wr_i = 0, ctx_b_sel_i = 0, in_valid_i = 0;
  logic        in_ready_o, out_valid_o, out_ready_i, stall = 0, took = 0, cnt_mode = 0;
  iwr_pan_t    vpan_a = '0;
  logic [10:0] vzoom_a = 11'h002;
  iwr_fmt_t    fmt = '0;
  iwr_pixel_t  pix = '0;
  int          errors = 0, checks_done = 0, cyc = 0;

  // Clock of 10 ns
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Vertical output size tied to zoom height, so every row is kept
  iwr_top iwr_top_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .ctx_b_sel_i(ctx_b_sel_i), .ctx_a_vertical_pan_i(vpan_a),
    .ctx_a_vertical_zoom_i(vzoom_a), .ctx_a_vertical_out_size_i(vzoom_a), .fmt_i(fmt), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_pixel_i(pix), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_data_o(out_data_o));
  iwr_rx_model iwr_rx_model_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .stall_i(stall),
    .out_ready_o(out_ready_i));

  // ============================================================
  // Checking and closing
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic results();
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Watcher: each word taken meets the oldest note, or is counted in count mode; also the hang limit
  always @(posedge clk_sys_i) begin
    took <= in_valid_i && in_ready_o;
    cyc <= cyc + 1;
    if (rst_b_i && out_valid_o && out_ready_i && cnt_mode) begin
      cnt <= cnt + 16'h0001;
    end else if (rst_b_i && out_valid_o && out_ready_i) begin
      check("out_data", out_data_o, expq.size() ? expq.pop_front() : 16'hXXXX);
    end
    // Hang limit last, so nothing runs after the closing report
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  // ============================================================
  // Register port: address held two edges past a write
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(posedge clk_sys_i);
    #1 reg_wr_i = 1'h0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    reg_addr_i = a;
    repeat (2) @(posedge clk_sys_i);
    #1 check("reg read", reg_rdata_o, e);
  endtask : rd

  // Expected word; chroma alternates from the line's first kept pixel
  function automatic logic [15:0] fw(iwr_pixel_t p, logic [7:0] q1, logic [7:0] q2, int k);
    logic       cr;
    logic [8:0] s;
    logic [7:0] c, r, b;
    cr = k[0] ^ fmt.chan_swap;
    s = cr ? p.c2 + q2 : p.c1 + q1;
    c = fmt.chroma_avg ? s[8:1] : (cr ? p.c2 : p.c1);
    r = fmt.chan_swap ? p.c2 : p.c0;
    b = fmt.chan_swap ? p.c0 : p.c2;
    if (fmt.rgb_en) begin
      s = '0;
      return fmt.byte_swap ? {p.c1[4:2], b[7:3], r[7:3], p.c1[7:5]} : {r[7:3], p.c1[7:2], b[7:3]};
    end
    return fmt.byte_swap ? {c, p.c0} : {p.c0, c};
  endfunction : fw

  // Raster frame of random pixels; notes the window's words
  task automatic frame(input int w, h, hs, hn, vs, vn);
    iwr_pixel_t p;
    int         k;
    logic [7:0] q1, q2;
    for (int y = 0; y < h; y++) begin
      k = 0;
      for (int x = 0; x < w; x++) begin
        p = {x == 0 && y == 0, x == 0, 8'($urandom), 8'($urandom), 8'($urandom)};
        pix = p;
        in_valid_i = 1'h1;
        do begin @(posedge clk_sys_i); #1; end while (!took);
        if (!cnt_mode && y >= vs && y < vs + vn && x >= hs && x < hs + hn) begin
          q1 = k == 0 ? p.c1 : q1;
          q2 = k == 0 ? p.c2 : q2;
          expq.push_back(fw(p, q1, q2, k));
          q1 = p.c1;
          q2 = p.c2;
          k++;
        end
      end
    end
    in_valid_i = 1'h0;
  endtask : frame

  task automatic drain();
    while (expq.size() != 0 || out_valid_o) @(posedge clk_sys_i);
    repeat (30) @(posedge clk_sys_i);
    #1;
  endtask : drain

  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'h314099F2));
    repeat (4) @(posedge clk_sys_i);
    #1 rst_b_i = 1'h1;
    for (int i = 0; i < 10; i++) begin
      rd(ADDR_CTX_B_HPAN + 9'(i), rv[i]);
    end
    wr(ADDR_CTX_B_HPAN, 16'hFFFF);
    rd(ADDR_CTX_B_HPAN, 16'h47FF);
    wr(ADDR_CTX_B_VZOOM, 16'hFFFF);
    rd(ADDR_CTX_B_VZOOM, 16'h07FF);
    wr(9'h1A8, 16'hFFFF);
    rd(9'h1A8, 16'h0000);
    // Size written before zoom so zoom never drops below size
    wr(ADDR_CTX_A_HSIZE, 16'h0008);
    wr(ADDR_CTX_A_HZOOM, 16'h0008);
    for (int f = 0; f < 16; f++) begin
      fmt = 4'(f);
      fmt.chroma_avg &= !fmt.rgb_en;
      frame(8, 2, 0, 8, 0, 2);
      drain();
    end
    fmt = 4'(4'($urandom) & 4'hB);
    wr(ADDR_CTX_A_HPAN, 16'h0003);
    wr(ADDR_CTX_A_HSIZE, 16'h0002);
    wr(ADDR_CTX_A_HZOOM, 16'h0002);
    vpan_a = 12'h001;
    vzoom_a = 11'h001;
    frame(8, 3, 3, 2, 1, 1);
    drain();
    // Centred: 640-637-1 = column 2, 512-510-1 = row 1
    wr(ADDR_CTX_A_HPAN, 16'h4583);
    vpan_a = 12'hE02;
    vzoom_a = 11'h002;
    frame(8, 4, 2, 2, 1, 2);
    drain();
    wr(ADDR_CTX_B_HPAN, 16'h0001);
    wr(ADDR_CTX_B_HSIZE, 16'h0003);
    wr(ADDR_CTX_B_HZOOM, 16'h0003);
    wr(ADDR_CTX_B_VPAN, 16'h4601);
    wr(ADDR_CTX_B_VSIZE, 16'h0002);
    wr(ADDR_CTX_B_VZOOM, 16'h0002);
    ctx_b_sel_i = 1'h1;
    frame(8, 3, 1, 3, 0, 2);
    drain();
    ctx_b_sel_i = 1'h0;
    frame(8, 4, 2, 2, 1, 2);
    drain();
    // Half-width reduction: four words of every eight-pixel line
    wr(ADDR_CTX_A_HPAN, 16'h0000);
    wr(ADDR_CTX_A_HZOOM, 16'h0008);
    wr(ADDR_CTX_A_HSIZE, 16'h0004);
    vpan_a = 12'h000;
    cnt_mode = 1'h1;
    frame(8, 2, 0, 0, 0, 0);
    drain();
    check("kept count", cnt, 16'h0008);
    cnt_mode = 1'h0;
    wr(ADDR_CTX_A_HSIZE, 16'h0008);
    stall = 1'h1;
    fork
      frame(8, 2, 0, 8, 0, 2);
      begin
        repeat (30) @(posedge clk_sys_i);
        #1 check("in_ready", {15'h0000, in_ready_o}, 16'h0000);
        stall = 1'h0;
      end
    join
    drain();
    check("notes left", 16'(expq.size()), 16'h0000);
    results();
  end
endmodule : tb_top
